//--- fpcn_cfg.svh
// fpcn_cfg.svh: offsets, field positions and codes of the operand classifier
// assumes inclusion by its bare name, definitions only
`ifndef FPCN_CFG_SVH
`define FPCN_CFG_SVH

// register byte offsets, one 32-bit word each
`define FPCN_OFF_A0 8'h00
`define FPCN_OFF_A1 8'h04
`define FPCN_OFF_A2 8'h08
`define FPCN_OFF_B0 8'h0c
`define FPCN_OFF_B1 8'h10
`define FPCN_OFF_B2 8'h14
`define FPCN_OFF_CTRL 8'h18
`define FPCN_OFF_STAT 8'h1c
`define FPCN_OFF_R0 8'h20
`define FPCN_OFF_R1 8'h24
`define FPCN_OFF_R2 8'h28
`define FPCN_ADDR_BITS 7:0
`define FPCN_HSIZE_WORD 3'h2

// control word fields
`define FPCN_CTRL_GO 0
`define FPCN_CTRL_FMT 2:1
`define FPCN_CTRL_OP 4:3
`define FPCN_CTRL_TRAP 5
`define FPCN_CTRL_W 6
`define FPCN_CTRL_RST 6'h00

// status word fields
`define FPCN_ST_CLS_A 6:0
`define FPCN_ST_CLS_B 13:7
`define FPCN_ST_SIGNALING_NAN 14
`define FPCN_ST_TRAP_SIGNALING_NAN 15
`define FPCN_ST_TRAP_UNIMP 16
`define FPCN_ST_NAN_OUT 17
`define FPCN_ST_DONE 18

// one-hot class bit positions
`define FPCN_CL_NORM 0
`define FPCN_CL_DENORM 1
`define FPCN_CL_ZERO 2
`define FPCN_CL_INF 3
`define FPCN_CL_QNAN 4
`define FPCN_CL_SIGNALING_NAN 5
`define FPCN_CL_UNNORM 6

// single precision fields
`define FPCN_SGL_SIGN 31
`define FPCN_SGL_EXP 30:23
`define FPCN_SGL_FRAC 22:0
`define FPCN_SGL_QBIT 22
`define FPCN_SGL_EXP_MAX 15'h00ff
`define FPCN_SGL_DNAN 32'h7fff_ffff

// double precision fields
`define FPCN_DBL_SIGN 63
`define FPCN_DBL_EXP 62:52
`define FPCN_DBL_FRAC 51:0
`define FPCN_DBL_QBIT 51
`define FPCN_DBL_EXP_MAX 15'h07ff
`define FPCN_DBL_DNAN 64'h7fff_ffff_ffff_ffff

// extended precision fields
`define FPCN_EXT_SIGN 95
`define FPCN_EXT_EXP 94:80
`define FPCN_EXT_RSVD 79:64
`define FPCN_EXT_MANT 63:0
`define FPCN_EXT_INT 63
`define FPCN_EXT_FRAC 62:0
`define FPCN_EXT_QBIT 62
`define FPCN_EXT_EXP_MAX 15'h7fff
`define FPCN_EXT_MANT_ONES 64'hffff_ffff_ffff_ffff

// packed decimal fields
`define FPCN_PK_MARK 94:92
`define FPCN_PK_MARK_ALL 3'h7
`define FPCN_PK_EXP 91:80
`define FPCN_PK_EXP_ALL 12'hfff
`define FPCN_PK_INT 67:64
`define FPCN_PK_FRAC 63:0

`endif

//--- fpcn_pkg.sv
// fpcn_pkg: types of the operand classifier
// assumes fpcn_cfg.svh for field positions
`default_nettype none

package fpcn_pkg;
	// operand format selected in the control word
	typedef enum logic [1:0] {
		FPCN_FMT_SINGLE,
		FPCN_FMT_DOUBLE,
		FPCN_FMT_EXT,
		FPCN_FMT_PACKED
	} fpcn_fmt_t;

	// operation selected in the control word
	typedef enum logic [1:0] {
		FPCN_OP_DYADIC,
		FPCN_OP_MONADIC,
		FPCN_OP_DEFAULT_NAN
	} fpcn_op_t;

	// one-hot operand class
	typedef logic [6:0] fpcn_class_t;
endpackage : fpcn_pkg

`default_nettype wire

//--- fpcn_core.sv
// fpcn_core: operand classification and NaN handling with an AHB-Lite register slave
// assumes a single AHB-Lite master, zero-wait-state slave, hclk at 40 MHz
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "fpcn_cfg.svh"
`default_nettype none

module fpcn_core (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output fpcn_pkg::fpcn_class_t class_a,
	output fpcn_pkg::fpcn_class_t class_b,
	output logic signaling_nan,
	output logic trap_unimpl
);
	import fpcn_pkg::*;

	logic [95:0] opa;
	logic [95:0] opb;
	logic [95:0] res;
	logic [`FPCN_CTRL_W-1:0] ctrl;
	logic [7:0] addr_q;
	logic wr_q;
	logic rd_q;
	logic start;
	logic trap_signaling_nan;
	logic nan_out;
	logic done;
	fpcn_fmt_t res_fmt;
	fpcn_fmt_t fmt;
	fpcn_op_t op;
	fpcn_class_t next_cls_a;
	fpcn_class_t next_cls_b;
	logic nan_a;
	logic nan_b;
	logic signaling_nan_any;
	logic unimpl_any;
	logic dyadic;

	// field decode per format, common class decision except packed, which has its own
	function automatic fpcn_class_t classify(input logic [95:0] v, input fpcn_fmt_t f);
		logic [14:0] e;
		logic [14:0] emax;
		logic fz_min;
		logic fz_max;
		logic qb;
		logic ib;
		fpcn_class_t c;
		e = '0;
		emax = `FPCN_EXT_EXP_MAX;
		fz_min = 1'b0;
		fz_max = 1'b0;
		qb = 1'b0;
		ib = 1'b0;
		c = '0;
		unique case (f)
			FPCN_FMT_SINGLE: begin
				e = {7'h00, v[`FPCN_SGL_EXP]};
				emax = `FPCN_SGL_EXP_MAX;
				fz_min = (v[`FPCN_SGL_FRAC] == '0);
				fz_max = fz_min;
				qb = v[`FPCN_SGL_QBIT];
				ib = 1'b0;
			end
			FPCN_FMT_DOUBLE: begin
				e = {4'h0, v[`FPCN_DBL_EXP]};
				emax = `FPCN_DBL_EXP_MAX;
				fz_min = (v[`FPCN_DBL_FRAC] == '0);
				fz_max = fz_min;
				qb = v[`FPCN_DBL_QBIT];
				ib = 1'b0;
			end
			FPCN_FMT_EXT: begin
				e = v[`FPCN_EXT_EXP];
				emax = `FPCN_EXT_EXP_MAX;
				fz_min = (v[`FPCN_EXT_MANT] == '0);
				fz_max = (v[`FPCN_EXT_FRAC] == '0);
				qb = v[`FPCN_EXT_QBIT];
				ib = v[`FPCN_EXT_INT];
			end
			FPCN_FMT_PACKED: begin
				qb = v[`FPCN_EXT_QBIT];
			end
		endcase
		if (f == FPCN_FMT_PACKED) begin
			// special marks and exponent digits all ones
			if (v[`FPCN_PK_MARK] == `FPCN_PK_MARK_ALL && v[`FPCN_PK_EXP] == `FPCN_PK_EXP_ALL) begin
				if (v[`FPCN_PK_FRAC] == '0)
					c[`FPCN_CL_INF] = 1'b1;
				else if (qb)
					c[`FPCN_CL_QNAN] = 1'b1;
				else
					c[`FPCN_CL_SIGNALING_NAN] = 1'b1;
			end else if (v[`FPCN_PK_INT] == '0 && v[`FPCN_PK_FRAC] == '0) begin
				c[`FPCN_CL_ZERO] = 1'b1;
			end else begin
				c[`FPCN_CL_NORM] = 1'b1;
			end
		end else if (e == '0) begin
			if (fz_min)
				c[`FPCN_CL_ZERO] = 1'b1;
			else if (ib)
				c[`FPCN_CL_NORM] = 1'b1;
			else
				c[`FPCN_CL_DENORM] = 1'b1;
		end else if (e == emax) begin
			if (fz_max)
				c[`FPCN_CL_INF] = 1'b1;
			else if (qb)
				c[`FPCN_CL_QNAN] = 1'b1;
			else
				c[`FPCN_CL_SIGNALING_NAN] = 1'b1;
		end else if (f == FPCN_FMT_EXT && !ib) begin
			c[`FPCN_CL_UNNORM] = 1'b1;
		end else begin
			c[`FPCN_CL_NORM] = 1'b1;
		end
		return c;
	endfunction : classify

	// source NaN with its quiet bit forced; packed moves into extended
	function automatic logic [95:0] quieten(input logic [95:0] v, input fpcn_fmt_t f);
		logic [95:0] r;
		r = '0;
		unique case (f)
			FPCN_FMT_SINGLE: begin
				r[31:0] = v[31:0];
				r[`FPCN_SGL_QBIT] = 1'b1;
			end
			FPCN_FMT_DOUBLE: begin
				r[63:0] = v[63:0];
				r[`FPCN_DBL_QBIT] = 1'b1;
			end
			FPCN_FMT_EXT: begin
				r = v;
				r[`FPCN_EXT_RSVD] = '0;
				r[`FPCN_EXT_QBIT] = 1'b1;
			end
			FPCN_FMT_PACKED: begin
				r[`FPCN_EXT_SIGN] = v[`FPCN_EXT_SIGN];
				r[`FPCN_EXT_EXP] = `FPCN_EXT_EXP_MAX;
				r[`FPCN_EXT_MANT] = v[`FPCN_PK_FRAC];
				r[`FPCN_EXT_QBIT] = 1'b1;
			end
		endcase
		return r;
	endfunction : quieten

	// default NaN, every mantissa bit one
	function automatic logic [95:0] default_nan(input fpcn_fmt_t f);
		logic [95:0] r;
		r = '0;
		unique case (f)
			FPCN_FMT_SINGLE: r[31:0] = `FPCN_SGL_DNAN;
			FPCN_FMT_DOUBLE: r[63:0] = `FPCN_DBL_DNAN;
			FPCN_FMT_EXT, FPCN_FMT_PACKED: begin
				r[`FPCN_EXT_EXP] = `FPCN_EXT_EXP_MAX;
				r[`FPCN_EXT_MANT] = `FPCN_EXT_MANT_ONES;
			end
		endcase
		return r;
	endfunction : default_nan

	// zero-wait-state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign fmt = fpcn_fmt_t'(ctrl[`FPCN_CTRL_FMT]);
	assign op = fpcn_op_t'(ctrl[`FPCN_CTRL_OP]);

	// address phase capture; writes must be whole-word, reads of any size
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (hready) begin
			addr_q <= haddr[`FPCN_ADDR_BITS];
			wr_q <= hsel && htrans[1] && hwrite && (hsize == `FPCN_HSIZE_WORD);
			rd_q <= hsel && htrans[1] && !hwrite;
		end
	end

	// operand and control writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opa <= '0;
			opb <= '0;
			ctrl <= `FPCN_CTRL_RST;
			start <= 1'b0;
		end else begin
			start <= wr_q && addr_q == `FPCN_OFF_CTRL && hwdata[`FPCN_CTRL_GO];
			if (wr_q) begin
				unique case (addr_q)
					`FPCN_OFF_A0: opa[31:0] <= hwdata;
					`FPCN_OFF_A1: opa[63:32] <= hwdata;
					`FPCN_OFF_A2: opa[95:64] <= hwdata;
					`FPCN_OFF_B0: opb[31:0] <= hwdata;
					`FPCN_OFF_B1: opb[63:32] <= hwdata;
					`FPCN_OFF_B2: opb[95:64] <= hwdata;
					`FPCN_OFF_CTRL: ctrl <= hwdata[`FPCN_CTRL_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// read mux over flops; unmapped offsets read zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_q) begin
			unique case (addr_q)
				`FPCN_OFF_A0: hrdata = opa[31:0];
				`FPCN_OFF_A1: hrdata = opa[63:32];
				`FPCN_OFF_A2: hrdata = opa[95:64];
				`FPCN_OFF_B0: hrdata = opb[31:0];
				`FPCN_OFF_B1: hrdata = opb[63:32];
				`FPCN_OFF_B2: hrdata = opb[95:64];
				`FPCN_OFF_CTRL: hrdata = {26'h0, ctrl[`FPCN_CTRL_W-1:1], 1'b0};
				`FPCN_OFF_STAT: begin
					hrdata[`FPCN_ST_CLS_A] = class_a;
					hrdata[`FPCN_ST_CLS_B] = class_b;
					hrdata[`FPCN_ST_SIGNALING_NAN] = signaling_nan;
					hrdata[`FPCN_ST_TRAP_SIGNALING_NAN] = trap_signaling_nan;
					hrdata[`FPCN_ST_TRAP_UNIMP] = trap_unimpl;
					hrdata[`FPCN_ST_NAN_OUT] = nan_out;
					hrdata[`FPCN_ST_DONE] = done;
				end
				`FPCN_OFF_R0: hrdata = res[31:0];
				`FPCN_OFF_R1: hrdata = res[63:32];
				`FPCN_OFF_R2: hrdata = res[95:64];
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// classify operand A, and operand B for dyadic operations only, in the current format
	assign dyadic = (op == FPCN_OP_DYADIC);
	assign next_cls_a = classify(opa, fmt);
	assign next_cls_b = dyadic ? classify(opb, fmt) : '0;
	assign nan_a = next_cls_a[`FPCN_CL_QNAN] | next_cls_a[`FPCN_CL_SIGNALING_NAN];
	assign nan_b = next_cls_b[`FPCN_CL_QNAN] | next_cls_b[`FPCN_CL_SIGNALING_NAN];
	assign signaling_nan_any = next_cls_a[`FPCN_CL_SIGNALING_NAN] | next_cls_b[`FPCN_CL_SIGNALING_NAN];
	assign unimpl_any = next_cls_a[`FPCN_CL_DENORM] | next_cls_a[`FPCN_CL_UNNORM]
		| next_cls_b[`FPCN_CL_DENORM] | next_cls_b[`FPCN_CL_UNNORM];

	// class and signaling flag registered when an operation is accepted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			class_a <= '0;
			class_b <= '0;
			signaling_nan <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			class_a <= next_cls_a;
			class_b <= next_cls_b;
			signaling_nan <= signaling_nan_any;
			done <= 1'b1;
		end
	end

	// result: NaN handling has priority over the unimplemented trap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res <= '0;
			res_fmt <= FPCN_FMT_SINGLE;
			nan_out <= 1'b0;
			trap_signaling_nan <= 1'b0;
			trap_unimpl <= 1'b0;
		end else if (start) begin
			res_fmt <= (fmt == FPCN_FMT_PACKED) ? FPCN_FMT_EXT : fmt;
			nan_out <= 1'b0;
			trap_signaling_nan <= 1'b0;
			trap_unimpl <= 1'b0;
			unique case (op)
				FPCN_OP_DEFAULT_NAN: begin
					res <= default_nan(fmt);
					nan_out <= 1'b1;
				end
				FPCN_OP_DYADIC, FPCN_OP_MONADIC: begin
					if (signaling_nan_any && ctrl[`FPCN_CTRL_TRAP]) begin
						trap_signaling_nan <= 1'b1; // destination left unchanged
					end else if (nan_a) begin
						res <= quieten(opa, fmt);
						nan_out <= 1'b1;
					end else if (nan_b) begin
						res <= quieten(opb, fmt);
						nan_out <= 1'b1;
					end else if (unimpl_any) begin
						trap_unimpl <= 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// helper: quiet bit of the held result
	logic res_qbit;
	always_comb begin
		unique case (res_fmt)
			FPCN_FMT_SINGLE: res_qbit = res[`FPCN_SGL_QBIT];
			FPCN_FMT_DOUBLE: res_qbit = res[`FPCN_DBL_QBIT];
			default: res_qbit = res[`FPCN_EXT_QBIT];
		endcase
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence go_gen_s;
		start && op == FPCN_OP_DEFAULT_NAN && fmt == FPCN_FMT_EXT;
	endsequence
	sequence go_nan_s;
		start && (dyadic || op == FPCN_OP_MONADIC) && (nan_a || nan_b) && !(signaling_nan_any && ctrl[`FPCN_CTRL_TRAP]);
	endsequence

	nan_result_a: assert property (go_nan_s |=> nan_out && res_qbit)
		else $error("NaN operand did not give a NaN result");
	quiet_out_a: assert property (nan_out |-> res_qbit)
		else $error("result NaN is signaling");
	default_nan_a: assert property (go_gen_s |=> res[`FPCN_EXT_MANT] == `FPCN_EXT_MANT_ONES
		&& res[`FPCN_EXT_EXP] == `FPCN_EXT_EXP_MAX)
		else $error("default NaN mantissa not all ones");
	rsvd_zero_a: assert property (nan_out && res_fmt == FPCN_FMT_EXT |-> res[`FPCN_EXT_RSVD] == '0)
		else $error("extended reserved bits not zero");
	class_onehot_a: assert property (done |-> $onehot(class_a))
		else $error("class of operand A not one-hot");
	signaling_nan_trap_a: assert property (start && signaling_nan_any && ctrl[`FPCN_CTRL_TRAP] && (dyadic || op == FPCN_OP_MONADIC)
		|=> trap_signaling_nan && !nan_out && $stable(res))
		else $error("trapped signaling NaN wrote a result");
	a_first_a: assert property (go_nan_s ##0 (nan_a && nan_b) |=> res == quieten($past(opa), $past(fmt)))
		else $error("operand A NaN did not win");
	unimpl_trap_a: assert property (start && unimpl_any && !nan_a && !nan_b && (dyadic || op == FPCN_OP_MONADIC)
		&& !signaling_nan_any |=> trap_unimpl && !nan_out)
		else $error("denormal operand did not raise the unimplemented trap");
	packed_load_a: assert property (go_nan_s ##0 (fmt == FPCN_FMT_PACKED && nan_a)
		|=> res[`FPCN_EXT_FRAC] == ($past(opa[`FPCN_EXT_FRAC]) | (63'h1 << `FPCN_EXT_QBIT))
		&& res[`FPCN_EXT_EXP] == `FPCN_EXT_EXP_MAX)
		else $error("packed NaN fraction not moved into the mantissa");
endmodule : fpcn_core

`default_nettype wire

//--- fpcn_ahb_host.sv
// fpcn_ahb_host: single-word AHB-Lite master standing in for the instruction pipeline
// assumes one slave whose hreadyout is looped back as hready
`default_nettype none
module fpcn_ahb_host (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic hung
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hung = 1'b0;
	end

	// bounded wait for hready at a rising edge
	task automatic wait_rdy();
		int i;
		for (i = 0; i < 32; i++) begin
			@(posedge hclk);
			if (hready === 1'b1) return;
		end
		hung = 1'b1;
	endtask : wait_rdy

	// one word transfer; released lines flip so stale values never look valid
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		hwdata <= ~d;
		haddr <= ~{24'h0, a};
	endtask : xfer
endmodule : fpcn_ahb_host
`default_nettype wire

//--- fp_operand_classify_nan_tb_top.sv
// fp_operand_classify_nan_tb_top: corner and random operations through the register bus
// assumes fpcn_core, fpcn_ahb_host and the offsets of fpcn_cfg.svh
`include "fpcn_cfg.svh"
`default_nettype none
module fp_operand_classify_nan_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hready, hresp, signaling_nan, trap_unimpl, hung;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	fpcn_pkg::fpcn_class_t class_a, class_b;
	logic [95:0] res_q = 96'h0;
	logic [31:0] seed = 32'h02c03faf;
	int n_mismatch = 0;
	int n_tests = 0;

	// 40 MHz clock
	always #12.5 hclk = ~hclk;

	fpcn_ahb_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));

	fpcn_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .class_a(class_a), .class_b(class_b),
		.signaling_nan(signaling_nan), .trap_unimpl(trap_unimpl));

	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_out

	// xorshift source
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// one-hot class of an operand
	function automatic fpcn_pkg::fpcn_class_t cls(input logic [1:0] f, input logic [95:0] x);
		logic [14:0] e;
		logic [14:0] mx;
		logic [63:0] m;
		case (f)
			2'h0: begin
				e = {7'h0, x[30:23]};
				mx = 15'h00ff;
				m = {x[30:23] != 8'h0, x[22:0], 40'h0};
			end
			2'h1: begin
				e = {4'h0, x[62:52]};
				mx = 15'h07ff;
				m = {x[62:52] != 11'h0, x[51:0], 11'h0};
			end
			default: begin
				e = x[94:80];
				mx = 15'h7fff;
				m = x[63:0];
			end
		endcase
		if (e == mx) begin
			if (f == 2'h3 ? m == 64'h0 : m[62:0] == 63'h0) return 7'h1 << `FPCN_CL_INF;
			return m[62] ? 7'h1 << `FPCN_CL_QNAN : 7'h1 << `FPCN_CL_SIGNALING_NAN;
		end
		if (f == 2'h3) return (x[67:0] == 68'h0) ? 7'h1 << `FPCN_CL_ZERO : 7'h1 << `FPCN_CL_NORM;
		if (e == 15'h0 && m == 64'h0) return 7'h1 << `FPCN_CL_ZERO;
		if (m[63]) return 7'h1 << `FPCN_CL_NORM;
		return (e == 15'h0) ? 7'h1 << `FPCN_CL_DENORM : 7'h1 << `FPCN_CL_UNNORM;
	endfunction : cls

	// source NaN with its quiet bit forced; packed lands as extended
	function automatic logic [95:0] quiet(input logic [1:0] f, input logic [95:0] x);
		case (f)
			2'h0: return {64'h0, x[31:23], 1'b1, x[21:0]};
			2'h1: return {32'h0, x[63:52], 1'b1, x[50:0]};
			default: return {x[95:80], 16'h0, x[63], 1'b1, x[61:0]};
		endcase
	endfunction : quiet

	// generated NaN pattern
	function automatic logic [95:0] dnan(input logic [1:0] f);
		case (f)
			2'h0: return {64'h0, 32'h7fff_ffff};
			2'h1: return {32'h0, 64'h7fff_ffff_ffff_ffff};
			default: return {16'h7fff, 16'h0, 64'hffff_ffff_ffff_ffff};
		endcase
	endfunction : dnan

	// random operand shaped by k: exponent ones, exponent zero, fraction zero
	function automatic logic [95:0] mk(input logic [1:0] f, input logic [2:0] k);
		logic [95:0] x;
		logic [95:0] em;
		logic [95:0] fm;
		x = {rnd(), rnd(), rnd()};
		em = (f == 2'h0) ? 96'h7f80_0000 : (f == 2'h1) ? 96'h7ff0_0000_0000_0000 : {1'b0, 15'h7fff, 80'h0};
		fm = (f == 2'h0) ? 96'h7f_ffff : (f == 2'h1) ? 96'hf_ffff_ffff_ffff : (f == 2'h2) ? {32'h0, {64{1'b1}}} : {28'h0, {68{1'b1}}};
		if (k[0]) x = x | em;
		else if (k[1]) x = x & ~em;
		if (k[2]) x = x & ~fm;
		return x;
	endfunction : mk

	// load operands, start, then read status and result back
	task automatic run(input logic [1:0] f, input logic [1:0] op, input logic tr, input logic [95:0] a, input logic [95:0] b);
		fpcn_pkg::fpcn_class_t ca;
		fpcn_pkg::fpcn_class_t cb;
		logic sn, na, nb, trp, un, no;
		logic [31:0] q;
		int i;
		ca = cls(f, a);
		cb = (op == 2'h0) ? cls(f, b) : 7'h00;
		sn = ca[`FPCN_CL_SIGNALING_NAN] | cb[`FPCN_CL_SIGNALING_NAN];
		na = ca[`FPCN_CL_QNAN] | ca[`FPCN_CL_SIGNALING_NAN];
		nb = cb[`FPCN_CL_QNAN] | cb[`FPCN_CL_SIGNALING_NAN];
		trp = sn & tr;
		no = (na | nb) & ~trp;
		un = ~na & ~nb & (|{ca[1], ca[6], cb[1], cb[6]}); // denormal or unnormal
		if (op == 2'h3) {trp, no, un} = 3'h0; // no-op gives no trap and no result; classes, signaling flag and done still update
		if (op == 2'h2) res_q = dnan(f);
		else if (no) res_q = quiet(f, na ? a : b);
		for (i = 0; i < 3; i++) host.xfer(1'b1, 8'(`FPCN_OFF_A0 + 4 * i), a[32 * i +: 32], q);
		for (i = 0; i < 3; i++) host.xfer(1'b1, 8'(`FPCN_OFF_B0 + 4 * i), b[32 * i +: 32], q);
		host.xfer(1'b1, `FPCN_OFF_CTRL, {26'h0, tr, op, f, 1'b1}, q);
		host.xfer(1'b0, `FPCN_OFF_STAT, 32'h0, q);
		if (op != 2'h2) begin
			chk_word("status", {13'h0, 1'b1, no, un, trp, sn, cb, ca}, q);
			chk_out("ports", {cb, ca, sn, un}, {class_b, class_a, signaling_nan, trap_unimpl});
		end
		for (i = 0; i < 3; i++) begin
			host.xfer(1'b0, 8'(`FPCN_OFF_R0 + 4 * i), 32'h0, q);
			chk_word("result", res_q[32 * i +: 32], q);
		end
	endtask : run

	// a stuck bus ends the run
	always @(posedge hung) begin
		n_mismatch++;
		print_verdict();
	end

	// reset, corner cases, then random operations
	initial begin
		logic [31:0] q;
		logic [1:0] f;
		int n;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		host.xfer(1'b0, 8'h40, 32'h0, q);
		chk_word("unmapped", 32'h0, q);
		run(2'h2, 2'h0, 1'b0, {16'hffff, 16'hbeef, 64'h8000_0000_0000_0001}, {16'h7fff, 16'h0, 64'h4000_0000_0000_0000});
		run(2'h0, 2'h0, 1'b1, 96'h3f80_0000, 96'h7f80_0001);
		run(2'h3, 2'h1, 1'b0, {16'hffff, 12'h0, 4'h0, 64'h8000_0000_0000_1234}, 96'h0);
		run(2'h2, 2'h1, 1'b0, {16'h0000, 16'h0, 64'h8000_0000_0000_0000}, 96'h0);
		for (n = 0; n < 4; n++) run(2'(n), 2'h2, 1'b0, 96'h0, 96'h0);
		for (n = 0; n < 150; n++) begin
			f = 2'(rnd());
			run(f, 2'(rnd()), 1'(rnd()), mk(f, 3'(rnd())), mk(f, 3'(rnd())));
		end
		print_verdict();
	end
endmodule : fp_operand_classify_nan_tb_top
`default_nettype wire
